// file: hw/processor_control_pkg.sv
/*
  Constants shared by the processor control unit: register map, command word
  layout, status bit positions, operation codes, states and clock adjustments.
  Assumes a 32-bit Avalon-MM slave with byte addresses on a 5-bit address.
*/
`default_nettype none
package processor_control_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [4:0] OFF_CMD = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_CLOCKS = 5'h08;
  localparam logic [4:0] OFF_RESULT = 5'h0C;
  localparam logic [4:0] OFF_BRANCH_BASE = 5'h10;
  localparam logic [4:0] OFF_PORT_POINTER = 5'h14;
  localparam logic [4:0] OFF_COUNT_BYTE = 5'h18;
  localparam logic [4:0] OFF_HAND_OFF_CAP = 5'h1C;

  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_SEL_BIT = 4;
  localparam int CMD_WORD_BIT = 5;
  localparam int CMD_ODD_BIT = 6;
  localparam int CMD_XFER_BIT = 7;
  localparam int CMD_IMM_LSB = 8;
  localparam int CMD_BASE_LSB = 16;
  localparam int CMD_EA_LSB = 24;
  localparam int CMD_TRN_LSB = 28;

  // status word fields
  localparam int ST_CARRY = 0;
  localparam int ST_STEP = 1;
  localparam int ST_IE = 2;
  localparam int ST_HALT = 3;
  localparam int ST_WAIT = 4;
  localparam int ST_LOCK = 5;
  localparam int ST_BUSY = 6;
  localparam int ST_SHADOW = 7;
  localparam int ST_NMI_PEND = 8;
  localparam int ST_LOCK_PEND = 9;
  localparam int ST_STATE_LSB = 12;

  // reset values
  localparam logic [31:0] CMD_RST = 32'h0000_0000;
  localparam logic [15:0] WORD16_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [5:0] OPC6_RST = 6'h00;

  // clock adjustments and constant shift count
  localparam logic [15:0] WORD_PENALTY_CLKS = 16'h0004;
  localparam logic [15:0] STALL_CLKS = 16'h0001;
  localparam logic [15:0] SHIFT_ONE = 16'h0001;

  typedef enum logic [3:0] {
    no_operation_op = 4'h0,
    set_carry_op = 4'h1,
    clear_carry_op = 4'h2,
    shift_count_op = 4'h3,
    set_string_step_op = 4'h4,
    clear_string_step_op = 4'h5,
    set_int_enable_op = 4'h6,
    clear_int_enable_op = 4'h7,
    halt_op = 4'h8,
    wait_test_op = 4'h9,
    coproc_hand_off_op = 4'hA,
    lock_prefix_op = 4'hB,
    soft_int_op = 4'hC,
    generic_op = 4'hD,
    short_branch_op = 4'hE,
    port_select_op = 4'hF
  } op_t;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_exec = 3'b001,
    st_opnd_stall = 3'b010,
    st_opnd_req = 3'b011,
    st_halt = 3'b100,
    st_wait = 3'b101
  } state_t;
endpackage
`default_nettype wire

// file: hw/processor_control_unit.sv
/*
  Processor control instruction unit: flag operations, halt, wait on test,
  coprocessor hand-off, bus lock prefix, no-operation, operand range forming
  and per-instruction clock count. Commands arrive over an Avalon-MM slave.
  Assumes all pin inputs are synchronous to i_core_clk and that the operand
  bus answers each request with a one-cycle i_opnd_ack.
*/
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - set_carry_op sets carry flag, other flags untouched.
// - clear_string_step_op clears step flag; string indexes then increment.
// - set_string_step_op sets step flag; string indexes then decrement.
// - clear_int_enable_op clears interrupt enable; maskable requests then ignored.
// - non-maskable and software interrupts are served regardless of enable.
// - set_int_enable_op sets interrupt enable, allowing maskable requests.
// - after enabling, maskable interrupt waits until the next instruction finishes.
// - halt_op halts; exit on reset, non-maskable, or enabled maskable request.
// - wait instruction holds while test input inactive, flags untouched.
// - hand-off carries 6-bit external opcode 0-63, visible when fetched.
// - hand-off register source does nothing; memory source read and discarded.
// - one-byte lock prefix asserts bus lock through next instruction, max mode.
// - no_operation_op does nothing and changes no flag.
// - control-transfer clock counts include queue refill and target fetch.
// - 16-bit bus: odd-address word reference adds four clocks.
// - 8-bit bus: every 16-bit memory reference adds four clocks, stack included.
// - operand need during started fetch stalls at most one clock.
// - queue full means bus idle, so operand access has no wait.
// - short branch target is end address plus signed byte, -128..+127.
// - port number is immediate 0-255 or port pointer register 0-64k.
// - shift count is constant 1 or count byte register 0-255.
// - software interrupt type is an immediate 0-255.
module processor_control_unit #(
  parameter bit BUS_16 = 1'b1,
  parameter logic [15:0] REFILL_CLKS = 16'h0008,
  parameter logic [7:0] NMI_TYPE = 8'h02
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_max_mode,
  input wire logic i_test_n,
  input wire logic i_maskable_irq,
  input wire logic [7:0] i_maskable_irq_type,
  input wire logic i_nonmaskable_irq,
  input wire logic i_fetch_busy,
  input wire logic i_queue_full,
  input wire logic i_opnd_ack,
  input wire logic [15:0] i_opnd_data,
  output logic o_opnd_req,
  output logic o_fetch_en,
  output logic o_bus_lock,
  output logic o_int_take,
  output logic o_int_ack,
  output logic [7:0] o_int_type,
  output logic o_esc_strobe,
  output logic [5:0] o_esc_opcode,
  output logic o_carry_flag,
  output logic o_string_step_flag,
  output logic o_int_enable_flag,
  output logic o_halted,
  output logic o_insn_done
);
  processor_control_pkg::state_t state_r;
  processor_control_pkg::state_t state_nxt;
  processor_control_pkg::op_t op;
  logic [31:0] cmd_r;
  logic [31:0] cmd_nxt;
  logic [7:0] imm;
  logic mem_sel;
  logic cmd_hit;
  logic cmd_acc;
  logic reg_wr;
  logic [15:0] clocks_r;
  logic [15:0] result_r;
  logic [15:0] branch_base_r;
  logic [15:0] port_pointer_r;
  logic [7:0] count_byte_r;
  logic [15:0] hand_off_data_r;
  logic carry_r;
  logic step_r;
  logic ie_r;
  logic shadow_r;
  logic nmi_q_r;
  logic nmi_pend_r;
  logic lock_pend_r;
  logic lock_act_r;
  logic rd_pend_r;
  logic [31:0] rd_mux;
  logic [31:0] status_w;
  logic int_now;
  logic int_nmi;
  logic int_mask;
  logic int_soft;
  logic done;
  logic needs_opnd;

  // merges a bus write into a word honouring byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // clock count from base, address calculation, word penalty and refill
  function automatic logic [15:0] static_clks(input logic [31:0] w);
    logic [15:0] pen;
    logic hit;
    logic [15:0] trn;
    hit = w[processor_control_pkg::CMD_SEL_BIT] &
          (BUS_16 ? (w[processor_control_pkg::CMD_WORD_BIT] &
                     w[processor_control_pkg::CMD_ODD_BIT])
                  : w[processor_control_pkg::CMD_WORD_BIT]);
    trn = {13'h0000, w[processor_control_pkg::CMD_TRN_LSB +: 3]};
    pen = hit ? 16'(trn * processor_control_pkg::WORD_PENALTY_CLKS) : 16'h0000;
    return 16'({8'h00, w[processor_control_pkg::CMD_BASE_LSB +: 8]}
               + {12'h000, w[processor_control_pkg::CMD_EA_LSB +: 4]} + pen
               + (w[processor_control_pkg::CMD_XFER_BIT] ? REFILL_CLKS : 16'h0000));
  endfunction

  // command word decode
  assign op = processor_control_pkg::op_t'(cmd_r[processor_control_pkg::CMD_OP_LSB +: 4]);
  assign imm = cmd_r[processor_control_pkg::CMD_IMM_LSB +: 8];
  assign mem_sel = cmd_r[processor_control_pkg::CMD_SEL_BIT];
  assign needs_opnd = mem_sel & ((op == processor_control_pkg::coproc_hand_off_op) |
                                 (op == processor_control_pkg::generic_op));

  // interrupt recognition at instruction boundaries and in halt
  assign int_nmi = nmi_pend_r;
  assign int_mask = i_maskable_irq & ie_r & ~shadow_r;
  assign int_soft = (state_r == processor_control_pkg::st_exec) &
                    (op == processor_control_pkg::soft_int_op);
  assign int_now = int_soft |
                   (((state_r == processor_control_pkg::st_idle) |
                     (state_r == processor_control_pkg::st_halt)) & (int_nmi | int_mask));

  // bus slave handshake: reads take two cycles, command writes stall while busy
  assign cmd_hit = i_avs_write & (i_avs_address == processor_control_pkg::OFF_CMD);
  assign o_avs_waitrequest = (i_avs_read & ~rd_pend_r) |
                             (cmd_hit & ((state_r != processor_control_pkg::st_idle) | int_now));
  assign cmd_acc = cmd_hit & ~o_avs_waitrequest;
  assign reg_wr = i_avs_write & ~o_avs_waitrequest;
  assign cmd_nxt = be_merge(cmd_r, i_avs_writedata, i_avs_byteenable);

  // instruction completion
  always_comb begin
    done = 1'b0;
    case (state_r)
      processor_control_pkg::st_exec: begin
        done = ~needs_opnd & (op != processor_control_pkg::wait_test_op);
      end
      processor_control_pkg::st_opnd_req: begin
        done = i_opnd_ack;
      end
      processor_control_pkg::st_wait: begin
        done = ~i_test_n;
      end
      default: begin
        done = 1'b0;
      end
    endcase
  end

  // sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      processor_control_pkg::st_idle: begin
        if (cmd_acc) begin
          state_nxt = processor_control_pkg::st_exec;
        end
      end
      processor_control_pkg::st_exec: begin
        if (op == processor_control_pkg::halt_op) begin
          state_nxt = processor_control_pkg::st_halt;
        end else if (op == processor_control_pkg::wait_test_op) begin
          state_nxt = processor_control_pkg::st_wait;
        end else if (needs_opnd) begin
          if (i_fetch_busy & ~i_queue_full) begin
            state_nxt = processor_control_pkg::st_opnd_stall;
          end else begin
            state_nxt = processor_control_pkg::st_opnd_req;
          end
        end else begin
          state_nxt = processor_control_pkg::st_idle;
        end
      end
      processor_control_pkg::st_opnd_stall: begin
        state_nxt = processor_control_pkg::st_opnd_req;
      end
      processor_control_pkg::st_opnd_req: begin
        if (i_opnd_ack) begin
          state_nxt = processor_control_pkg::st_idle;
        end
      end
      processor_control_pkg::st_halt: begin
        if (int_nmi | (i_maskable_irq & ie_r)) begin
          state_nxt = processor_control_pkg::st_idle;
        end
      end
      processor_control_pkg::st_wait: begin
        if (~i_test_n) begin
          state_nxt = processor_control_pkg::st_idle;
        end
      end
      default: begin
        state_nxt = processor_control_pkg::st_idle;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= processor_control_pkg::st_idle;
    end else begin
      state_r <= state_nxt;
    end
  end

  // command word and clock count of the instruction in progress
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmd_r <= processor_control_pkg::CMD_RST;
      clocks_r <= processor_control_pkg::WORD16_RST;
    end else if (cmd_acc) begin
      cmd_r <= cmd_nxt;
      clocks_r <= static_clks(cmd_nxt);
    end else if (state_r == processor_control_pkg::st_opnd_stall) begin
      clocks_r <= clocks_r + processor_control_pkg::STALL_CLKS;
    end
  end

  // flags: only the flag operations and interrupt entry touch them
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      carry_r <= 1'b0;
      step_r <= 1'b0;
      ie_r <= 1'b0;
    end else if (int_now) begin
      ie_r <= 1'b0;
    end else if (state_r == processor_control_pkg::st_exec) begin
      case (op)
        processor_control_pkg::set_carry_op: carry_r <= 1'b1;
        processor_control_pkg::clear_carry_op: carry_r <= 1'b0;
        processor_control_pkg::set_string_step_op: step_r <= 1'b1;
        processor_control_pkg::clear_string_step_op: step_r <= 1'b0;
        processor_control_pkg::set_int_enable_op: ie_r <= 1'b1;
        processor_control_pkg::clear_int_enable_op: ie_r <= 1'b0;
        default: begin
          carry_r <= carry_r;
        end
      endcase
    end
  end

  // one-instruction shadow after enabling interrupts
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      shadow_r <= 1'b0;
    end else if ((state_r == processor_control_pkg::st_exec) &
                 (op == processor_control_pkg::set_int_enable_op)) begin
      shadow_r <= 1'b1;
    end else if (done) begin
      shadow_r <= 1'b0;
    end
  end

  // non-maskable request latch, set wins over clear
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      nmi_q_r <= 1'b0;
      nmi_pend_r <= 1'b0;
    end else begin
      nmi_q_r <= i_nonmaskable_irq;
      if (i_nonmaskable_irq & ~nmi_q_r) begin
        nmi_pend_r <= 1'b1;
      end else if (int_now & ~int_soft) begin
        nmi_pend_r <= 1'b0;
      end
    end
  end

  // interrupt entry outputs: nmi first, then maskable, software from command
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_int_take <= 1'b0;
      o_int_ack <= 1'b0;
      o_int_type <= processor_control_pkg::BYTE_RST;
    end else begin
      o_int_take <= int_now;
      o_int_ack <= int_now & ~int_soft & ~int_nmi;
      if (int_soft) begin
        o_int_type <= imm;
      end else if (int_now & int_nmi) begin
        o_int_type <= NMI_TYPE;
      end else if (int_now) begin
        o_int_type <= i_maskable_irq_type;
      end
    end
  end

  // lock prefix: armed by the prefix, held across the next instruction
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lock_pend_r <= 1'b0;
      lock_act_r <= 1'b0;
    end else begin
      if ((state_r == processor_control_pkg::st_exec) &
          (op == processor_control_pkg::lock_prefix_op)) begin
        lock_pend_r <= i_max_mode;
        lock_act_r <= 1'b0;
      end else if (cmd_acc & lock_pend_r) begin
        lock_pend_r <= 1'b0;
        lock_act_r <= 1'b1;
      end else if (done) begin
        lock_act_r <= 1'b0;
      end
    end
  end

  // coprocessor hand-off: opcode strobe and discarded operand capture
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_esc_strobe <= 1'b0;
      o_esc_opcode <= processor_control_pkg::OPC6_RST;
      hand_off_data_r <= processor_control_pkg::WORD16_RST;
    end else begin
      o_esc_strobe <= cmd_acc & (cmd_nxt[processor_control_pkg::CMD_OP_LSB +: 4] ==
                                 processor_control_pkg::coproc_hand_off_op);
      if (cmd_acc & (cmd_nxt[processor_control_pkg::CMD_OP_LSB +: 4] ==
                     processor_control_pkg::coproc_hand_off_op)) begin
        o_esc_opcode <= cmd_nxt[processor_control_pkg::CMD_IMM_LSB +: 6];
      end
      if ((state_r == processor_control_pkg::st_opnd_req) & i_opnd_ack &
          (op == processor_control_pkg::coproc_hand_off_op)) begin
        hand_off_data_r <= i_opnd_data;
      end
    end
  end

  // operand forming: branch target, port number, shift count
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      result_r <= processor_control_pkg::WORD16_RST;
    end else if (state_r == processor_control_pkg::st_exec) begin
      case (op)
        processor_control_pkg::short_branch_op: begin
          result_r <= branch_base_r + {{8{imm[7]}}, imm};
        end
        processor_control_pkg::port_select_op: begin
          result_r <= mem_sel ? port_pointer_r : {8'h00, imm};
        end
        processor_control_pkg::shift_count_op: begin
          result_r <= mem_sel ? {8'h00, count_byte_r} : processor_control_pkg::SHIFT_ONE;
        end
        default: begin
          result_r <= result_r;
        end
      endcase
    end
  end

  // software-written operand registers
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      branch_base_r <= processor_control_pkg::WORD16_RST;
      port_pointer_r <= processor_control_pkg::WORD16_RST;
      count_byte_r <= processor_control_pkg::BYTE_RST;
    end else if (reg_wr) begin
      case (i_avs_address)
        processor_control_pkg::OFF_BRANCH_BASE: begin
          branch_base_r <= 16'(be_merge({16'h0000, branch_base_r}, i_avs_writedata,
                                        i_avs_byteenable));
        end
        processor_control_pkg::OFF_PORT_POINTER: begin
          port_pointer_r <= 16'(be_merge({16'h0000, port_pointer_r}, i_avs_writedata,
                                         i_avs_byteenable));
        end
        processor_control_pkg::OFF_COUNT_BYTE: begin
          if (i_avs_byteenable[0]) begin
            count_byte_r <= i_avs_writedata[7:0];
          end
        end
        default: begin
          count_byte_r <= count_byte_r;
        end
      endcase
    end
  end

  // status image
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[processor_control_pkg::ST_CARRY] = carry_r;
    status_w[processor_control_pkg::ST_STEP] = step_r;
    status_w[processor_control_pkg::ST_IE] = ie_r;
    status_w[processor_control_pkg::ST_HALT] = (state_r == processor_control_pkg::st_halt);
    status_w[processor_control_pkg::ST_WAIT] = (state_r == processor_control_pkg::st_wait);
    status_w[processor_control_pkg::ST_LOCK] = lock_act_r;
    status_w[processor_control_pkg::ST_BUSY] = (state_r != processor_control_pkg::st_idle);
    status_w[processor_control_pkg::ST_SHADOW] = shadow_r;
    status_w[processor_control_pkg::ST_NMI_PEND] = nmi_pend_r;
    status_w[processor_control_pkg::ST_LOCK_PEND] = lock_pend_r;
    status_w[processor_control_pkg::ST_STATE_LSB +: 3] = state_r;
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    case (i_avs_address)
      processor_control_pkg::OFF_CMD: rd_mux = cmd_r;
      processor_control_pkg::OFF_STATUS: rd_mux = status_w;
      processor_control_pkg::OFF_CLOCKS: rd_mux = {16'h0000, clocks_r};
      processor_control_pkg::OFF_RESULT: rd_mux = {16'h0000, result_r};
      processor_control_pkg::OFF_BRANCH_BASE: rd_mux = {16'h0000, branch_base_r};
      processor_control_pkg::OFF_PORT_POINTER: rd_mux = {16'h0000, port_pointer_r};
      processor_control_pkg::OFF_COUNT_BYTE: rd_mux = {24'h000000, count_byte_r};
      processor_control_pkg::OFF_HAND_OFF_CAP: rd_mux = {hand_off_data_r, 10'h000, o_esc_opcode};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // registered read data, answered on the second cycle of a read
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_pend_r <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      rd_pend_r <= i_avs_read & ~rd_pend_r;
      if (i_avs_read & ~rd_pend_r) begin
        o_avs_readdata <= rd_mux;
      end
    end
  end

  // pin-level outputs
  assign o_opnd_req = (state_r == processor_control_pkg::st_opnd_req);
  assign o_fetch_en = (state_r != processor_control_pkg::st_halt);
  assign o_bus_lock = lock_act_r;
  assign o_carry_flag = carry_r;
  assign o_string_step_flag = step_r;
  assign o_int_enable_flag = ie_r;
  assign o_halted = (state_r == processor_control_pkg::st_halt);
  assign o_insn_done = done;
endmodule // processor_control_unit
`default_nettype wire

// file: hw/unused_placeholder_never_created.sv
`default_nettype none
`default_nettype wire

// file: verif/processor_control_unit_checker.sv
/* port checker for the control unit; bound to every instance of it */
`timescale 1ns/100ps
`default_nettype none
module processor_control_unit_checker (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_max_mode,
  input wire logic i_nonmaskable_irq,
  input wire logic o_opnd_req,
  input wire logic o_fetch_en,
  input wire logic o_bus_lock,
  input wire logic o_int_ack,
  input wire logic o_carry_flag,
  input wire logic o_string_step_flag,
  input wire logic o_int_enable_flag,
  input wire logic o_halted,
  input wire logic o_insn_done
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // carry and step flags move, and interrupt enable rises, only at the edge closing an instruction
  a_carry_by_op: assert property (!$stable(o_carry_flag) |-> $past(o_insn_done))
    else $error("carry flag moved outside completion");
  a_step_by_op: assert property (!$stable(o_string_step_flag) |-> $past(o_insn_done))
    else $error("step flag moved outside completion");
  a_ie_rise_op: assert property ($rose(o_int_enable_flag) |-> $past(o_insn_done))
    else $error("interrupt enable rose outside completion");
  a_ack_needs_ie: assert property (o_int_ack |->
    $past(o_int_enable_flag) || $past(o_int_enable_flag, 2))
    else $error("maskable entry while disabled");
  a_halt_no_bus: assert property (o_halted |-> !o_fetch_en && !o_opnd_req)
    else $error("bus activity while halted");
  a_halt_entry: assert property ($rose(o_halted) |-> $past(o_insn_done))
    else $error("halt entered without an instruction");
  a_nmi_wakes: assert property (o_halted && $rose(i_nonmaskable_irq) |-> ##[1:4] !o_halted)
    else $error("non-maskable request left unit halted");
  a_lock_mode: assert property ($rose(o_bus_lock) |-> i_max_mode)
    else $error("bus lock outside maximum mode");
  // main scenarios reached
  c_int_ack: cover property (o_int_ack);
  c_lock: cover property (o_bus_lock);
  c_wake: cover property ($fell(o_halted));
endmodule // processor_control_unit_checker
bind processor_control_unit processor_control_unit_checker i_chk (.*);
`default_nettype wire

// file: verif/processor_control_opnd_model.sv
/* operand bus partner: answers a request i_delay + 1 cycles after it rises; one clock */
`timescale 1ns/100ps
`default_nettype none
module processor_control_opnd_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_req,
  input wire logic [1:0] i_delay,
  output logic o_ack,
  output logic [15:0] o_data
);
  logic [1:0] cnt_r;
  logic hit;
  assign hit = i_req && !o_ack && cnt_r == i_delay;
  // one ack per read; data stands only in the ack cycle, toggles otherwise
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_r <= 2'h0;
      o_ack <= 1'h0;
      o_data <= 16'hA5C3;
    end else begin
      o_ack <= hit;
      cnt_r <= (i_req && !o_ack && !hit) ? cnt_r + 2'h1 : 2'h0;
      o_data <= hit ? 16'h5A3C : ~o_data;
    end
  end
endmodule // processor_control_opnd_model
`default_nettype wire

// file: verif/processor_control_unit_tb_top.sv
/* testbench for the control unit; drives the register bus and pins, uses operand model */
`timescale 1ns/100ps
`default_nettype none
module processor_control_unit_tb_top;
  logic i_core_clk = 1'h0, i_nrst = 1'h0, i_avs_read = 1'h0, i_avs_write = 1'h0;
  logic [4:0] i_avs_address = 5'h00;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, rdat;
  logic [3:0] i_avs_byteenable = 4'hF;
  logic i_max_mode = 1'h1, i_test_n = 1'h0, i_maskable_irq = 1'h0, i_nonmaskable_irq = 1'h0;
  logic [7:0] i_maskable_irq_type = 8'h4C, o_int_type;
  logic i_fetch_busy = 1'h1, i_queue_full = 1'h0, i_opnd_ack, hit;
  logic [15:0] i_opnd_data;
  logic o_avs_waitrequest, o_opnd_req, o_fetch_en, o_bus_lock, o_int_take, o_int_ack;
  logic o_esc_strobe, o_carry_flag, o_string_step_flag, o_int_enable_flag, o_halted;
  logic o_insn_done;
  logic [5:0] o_esc_opcode;
  int n_fail = 0, n_compared = 0;
  always #25 i_core_clk = ~i_core_clk;
  processor_control_unit i_dut (.*);
  processor_control_opnd_model i_opnd (.i_clk(i_core_clk), .i_nrst(i_nrst),
    .i_req(o_opnd_req), .i_delay(2'h3), .o_ack(i_opnd_ack), .o_data(i_opnd_data));
  // comparisons and bus helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    do @(posedge i_core_clk); while (o_avs_waitrequest !== 1'h0);
    rdat = o_avs_readdata;
    i_avs_write <= 1'h0;
    i_avs_read <= 1'h0;
  endtask
  task automatic cmd(input logic [31:0] w);
    bus(1'h1, 5'h00, w);
    @(posedge i_core_clk);
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    bus(1'h0, 5'h04, 32'h0);
    chk(rdat & m, e);
  endtask
  task automatic seen(ref logic s);
    hit = 1'h0;
    repeat (8) begin
      @(posedge i_core_clk);
      if (s === 1'h1) hit = 1'h1;
    end
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // scenarios
  task automatic t_flags();
    cmd(32'h1);
    st(32'h7, 32'h1);
    cmd(32'h4);
    st(32'h7, 32'h3);
    cmd(32'h0);
    st(32'h7, 32'h3);
    cmd(32'h5);
    st(32'h7, 32'h1);
    bus(1'h0, 5'h02, 32'h0);
    chk(rdat, 32'h0);
  endtask
  task automatic t_irq();
    cmd(32'h7);
    i_maskable_irq <= 1'h1;
    seen(o_int_take);
    chk(32'(hit), 32'h0);
    cmd(32'h6);
    seen(o_int_take);
    chk(32'(hit), 32'h0);
    cmd(32'h0);
    seen(o_int_ack);
    chk(32'(hit), 32'h1);
    chk(32'(o_int_type), 32'h4C);
    i_maskable_irq <= 1'h0;
  endtask
  task automatic t_nmi();
    i_nonmaskable_irq <= 1'h1;
    seen(o_int_take);
    chk(32'(hit), 32'h1);
    chk(32'(o_int_type), 32'h2);
    i_nonmaskable_irq <= 1'h0;
  endtask
  task automatic t_halt();
    cmd(32'h8);
    @(posedge i_core_clk);
    chk(32'({o_halted, o_fetch_en}), 32'h2);
    i_nonmaskable_irq <= 1'h1;
    repeat (5) @(posedge i_core_clk);
    chk(32'(o_halted), 32'h0);
    i_nonmaskable_irq <= 1'h0;
  endtask
  task automatic t_wait();
    i_test_n <= 1'h1;
    cmd(32'h9);
    st(32'h10, 32'h10);
    i_test_n <= 1'h0;
    repeat (3) @(posedge i_core_clk);
    st(32'h10, 32'h0);
  endtask
  task automatic t_esc();
    cmd(32'h150A);
    chk(32'(o_esc_strobe), 32'h1);
    seen(o_opnd_req);
    chk(32'(hit), 32'h0);
    cmd(32'h3F1A);
    chk(32'(o_esc_opcode), 32'h3F);
    repeat (10) @(posedge i_core_clk);
    bus(1'h0, 5'h1C, 32'h0);
    chk(rdat & 32'hFFFF003F, 32'h5A3C003F);
  endtask
  task automatic t_lock();
    cmd(32'hB);
    bus(1'h1, 5'h00, 32'h0);
    seen(o_bus_lock);
    chk(32'(hit), 32'h1);
    i_max_mode <= 1'h0;
    cmd(32'hB);
    bus(1'h1, 5'h00, 32'h0);
    seen(o_bus_lock);
    chk(32'(hit), 32'h0);
  endtask
  // branch target, clock counts with and without fetch stall, software interrupt
  task automatic t_calc();
    bus(1'h1, 5'h10, 32'h1000);
    cmd(32'h800E);
    bus(1'h0, 5'h0C, 32'h0);
    chk(rdat, 32'h0F80);
    cmd(32'h1509_00FD);
    bus(1'h0, 5'h08, 32'h0);
    chk(rdat, 32'h1B);
    i_queue_full <= 1'h1;
    cmd(32'h1509_00FD);
    bus(1'h0, 5'h08, 32'h0);
    chk(rdat, 32'h1A);
    cmd(32'h210C);
    @(posedge i_core_clk);
    chk(32'(o_int_take), 32'h1);
    chk(32'(o_int_ack), 32'h0);
    chk(32'(o_int_type), 32'h21);
  endtask
  // main sequence, then watchdog
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_nrst <= 1'h1;
    t_flags();
    t_irq();
    t_nmi();
    t_halt();
    t_wait();
    t_esc();
    t_lock();
    t_calc();
    wrap_up();
  end
  initial begin
    repeat (3000) @(posedge i_core_clk);
    n_fail++;
    wrap_up();
  end
endmodule // processor_control_unit_tb_top
`default_nettype wire
